// *** logic/tou_params.svh ***
// offsets, field positions, reset values and timing counts of the timer overflow unit
`ifndef TOU_PARAMS_SVH
`define TOU_PARAMS_SVH
`define TOU_ADDR_W 8
`define TOU_OFF_COUNT 8'h01
`define TOU_OFF_OPTION 8'h81
`define TOU_OFF_IRQ_CTRL_B0 8'h0B
`define TOU_OFF_IRQ_CTRL_B1 8'h8B
`define TOU_BIT_GIE 7
`define TOU_BIT_PERIPHERAL_IRQ_ENABLE 6
`define TOU_BIT_OVF_EN 5
`define TOU_BIT_EXT_EN 4
`define TOU_BIT_PORT_EN 3
`define TOU_BIT_OVF_FLAG 2
`define TOU_BIT_EXT_FLAG 1
`define TOU_BIT_PORT_FLAG 0
`define TOU_BIT_SRC_SEL 5
`define TOU_BIT_EDGE_SEL 4
`define TOU_BIT_PSA 3
`define TOU_PS_LSB 0
`define TOU_PS_W 3
`define TOU_OPTION_RESET 8'hFF
`define TOU_IRQ_CTRL_RESET 8'h00
`define TOU_COUNT_RESET 8'h00
`define TOU_OSC_PER_INSTR 4
`define TOU_WRITE_HOLD_CYCLES 2
`endif

// *** logic/tou_pkg.sv ***
// shared types of the timer overflow unit
package tou_pkg;
  typedef logic [7:0] tou_byte_t;
  typedef logic [2:0] tou_ps_sel_t;
  typedef enum logic [1:0] {
    TOU_RUN = 2'b00,
    TOU_HOLD1 = 2'b01,
    TOU_HOLD2 = 2'b10
  } tou_hold_e;
endpackage

// *** logic/tou_edge_detect.sv ***
// edge detector for the external count pin with selectable polarity
`timescale 1ns/100ps
`include "tou_params.svh"
module tou_edge_detect (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // pin and selection
  input wire logic pin_in,
  input wire logic falling_sel,
  input wire logic enable,
  // result
  output logic edge_pulse
);
  logic prev_reg;
  logic prev_next;
  always_comb begin
    prev_next = pin_in;
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      // track the pin in reset so release never shows a false edge
      prev_reg <= pin_in;
    end else begin
      prev_reg <= prev_next;
    end
  end
  assign edge_pulse = enable & (falling_sel ? (prev_reg & ~pin_in) : (~prev_reg & pin_in));
endmodule

// *** logic/tou_prescaler.sv ***
// shared prescaler, divides a tick stream by a power of two
`timescale 1ns/100ps
`include "tou_params.svh"
module tou_prescaler #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // control
  input wire logic tick_in,
  input wire logic clear,
  input wire tou_pkg::tou_ps_sel_t ratio_sel,
  // divided tick
  output logic tick_out
);
  import tou_pkg::*;
  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] cnt_next;
  logic [WIDTH-1:0] mask;
  // ratio is two to the field plus one
  always_comb begin
    mask = WIDTH'((9'h002 << ratio_sel) - 9'h001);
    cnt_next = cnt_reg;
    tick_out = 1'b0;
    if (clear) begin
      cnt_next = '0;
    end else if (tick_in) begin
      if ((cnt_reg & mask) == mask) begin
        cnt_next = '0;
        tick_out = 1'b1;
      end else begin
        cnt_next = cnt_reg + WIDTH'(1);
      end
    end
  end
  // internal count has no bus path
  always_ff @(posedge clock) begin
    if (srst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule

// *** logic/tou_timer_unit.sv ***
// 8-bit timer/counter with overflow flag and interrupt control register
//
// Functional notes
// - source select clear counts instruction cycles
// - counter write blocks counting two cycles
// - source select set counts external pin
// - edge select: clear rising, set falling
// - prescaler serves counter or watchdog only
// - prescaler count never visible nor writable
// - counter prescale ratios 1:2 through 1:256
// - wrap FFh to 00h sets overflow flag
// - no overflow request while enable clear
// - timer stops during sleep
// - 8-bit counter, internal or pin source
// - control register layout and reset values
// - port change flag zero means no change
// - control register mirrored in both banks
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/100ps
`include "tou_params.svh"
module tou_timer_unit (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  input wire logic power_on_rst,
  // register port
  input wire logic [`TOU_ADDR_W-1:0] addr,
  input wire tou_pkg::tou_byte_t wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output tou_pkg::tou_byte_t rdata,
  // external events
  input wire logic ext_count_pin,
  input wire logic ext_pin_event,
  input wire logic port_change_event,
  input wire logic sleep_mode,
  // watchdog side
  input wire logic wdt_tick,
  output logic wdt_ps_tick,
  // core interrupt
  output logic irq_request
);
  import tou_pkg::*;

  logic [1:0] qdiv_reg;
  logic [1:0] qdiv_next;
  tou_byte_t count_reg;
  tou_byte_t count_next;
  tou_byte_t option_reg;
  tou_byte_t option_next;
  tou_byte_t irq_control_reg;
  tou_byte_t irq_control_next;
  tou_hold_e hold_reg;
  tou_hold_e hold_next;
  tou_byte_t rdata_reg;
  tou_byte_t rdata_next;
  logic irq_reg;
  logic irq_next;
  logic wdt_tick_reg;
  logic instr_tick;
  logic pin_edge;
  logic src_tick;
  logic ps_in;
  logic ps_out;
  logic count_tick;
  logic wr_count;
  logic wr_option;
  logic wr_irq;
  logic count_source_sel;
  logic source_edge_sel;
  logic prescaler_assign;
  logic overflow;

  function automatic logic is_irq_ctrl(input logic [`TOU_ADDR_W-1:0] a);
    // same register at both bank addresses
    return (a == `TOU_OFF_IRQ_CTRL_B0) || (a == `TOU_OFF_IRQ_CTRL_B1);
  endfunction

  assign count_source_sel = option_reg[`TOU_BIT_SRC_SEL];
  assign source_edge_sel = option_reg[`TOU_BIT_EDGE_SEL];
  assign prescaler_assign = option_reg[`TOU_BIT_PSA];
  assign wr_count = wr_en && (addr == `TOU_OFF_COUNT);
  assign wr_option = wr_en && (addr == `TOU_OFF_OPTION);
  assign wr_irq = wr_en && is_irq_ctrl(addr);

  // instruction cycle enable: oscillator divided by four
  always_comb begin
    qdiv_next = qdiv_reg + 2'h1;
  end
  assign instr_tick = (qdiv_reg == 2'(`TOU_OSC_PER_INSTR - 1));

  always_ff @(posedge clock) begin
    if (srst) begin
      qdiv_reg <= 2'h0;
    end else begin
      qdiv_reg <= qdiv_next;
    end
  end

  tou_edge_detect u_edge (
    .clock(clock),
    .srst(srst),
    .pin_in(ext_count_pin),
    .falling_sel(source_edge_sel),
    .enable(~sleep_mode),
    .edge_pulse(pin_edge)
  );

  assign src_tick = count_source_sel ? pin_edge : (instr_tick & ~sleep_mode);
  assign ps_in = prescaler_assign ? wdt_tick : src_tick;

  tou_prescaler #(
    .WIDTH(8)
  ) u_ps (
    .clock(clock),
    .srst(srst),
    .tick_in(ps_in),
    .clear(wr_count & ~prescaler_assign),
    .ratio_sel(option_reg[`TOU_PS_LSB +: `TOU_PS_W]),
    .tick_out(ps_out)
  );

  // bypass when prescaler belongs to watchdog
  assign count_tick = prescaler_assign ? src_tick : ps_out;

  // write hold sequencer, counts instruction cycles
  always_comb begin
    hold_next = hold_reg;
    if (wr_count) begin
      hold_next = TOU_HOLD2;
    end else if (instr_tick) begin
      unique case (hold_reg)
        TOU_RUN: hold_next = TOU_RUN;
        TOU_HOLD2: hold_next = TOU_HOLD1;
        TOU_HOLD1: hold_next = TOU_RUN;
        default: hold_next = TOU_RUN;
      endcase
    end
  end

  // counter and overflow detection
  always_comb begin
    count_next = count_reg;
    overflow = 1'b0;
    if (wr_count) begin
      count_next = wdata;
    end else if (count_tick && hold_reg == TOU_RUN && !sleep_mode) begin
      count_next = count_reg + 8'h01;
      overflow = (count_reg == 8'hFF);
    end
  end

  always_comb begin
    option_next = wr_option ? wdata : option_reg;
  end

  // interrupt control register
  always_comb begin
    irq_control_next = irq_control_reg;
    if (wr_irq) begin
      irq_control_next = wdata;
    end
    // set wins over a clearing write
    if (overflow) begin
      irq_control_next[`TOU_BIT_OVF_FLAG] = 1'b1;
    end
    if (ext_pin_event) begin
      irq_control_next[`TOU_BIT_EXT_FLAG] = 1'b1;
    end
    // flag stays zero without a port change or a software write of one
    if (port_change_event) begin
      irq_control_next[`TOU_BIT_PORT_FLAG] = 1'b1;
    end
  end

  // request gated by global and matching enables
  always_comb begin
    irq_next = irq_control_reg[`TOU_BIT_GIE] & (
      (irq_control_reg[`TOU_BIT_OVF_EN] & irq_control_reg[`TOU_BIT_OVF_FLAG]) |
      (irq_control_reg[`TOU_BIT_EXT_EN] & irq_control_reg[`TOU_BIT_EXT_FLAG]) |
      (irq_control_reg[`TOU_BIT_PORT_EN] & irq_control_reg[`TOU_BIT_PORT_FLAG]));
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rdata_next = 8'h00;
    if (rd_en) begin
      if (addr == `TOU_OFF_COUNT) begin
        rdata_next = count_reg;
      end else if (addr == `TOU_OFF_OPTION) begin
        rdata_next = option_reg;
      end else if (is_irq_ctrl(addr)) begin
        rdata_next = irq_control_reg;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      count_reg <= `TOU_COUNT_RESET;
      option_reg <= `TOU_OPTION_RESET;
      hold_reg <= TOU_RUN;
      rdata_reg <= 8'h00;
      irq_reg <= 1'b0;
      wdt_tick_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      option_reg <= option_next;
      hold_reg <= hold_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
      wdt_tick_reg <= prescaler_assign ? ps_out : wdt_tick;
    end
  end

  // reset clears all but port change flag, kept on warm reset
  always_ff @(posedge clock) begin
    if (srst) begin
      irq_control_reg[7:1] <= 7'(`TOU_IRQ_CTRL_RESET >> 1);
      if (power_on_rst) begin
        irq_control_reg[0] <= 1'(`TOU_IRQ_CTRL_RESET);
      end
    end else begin
      irq_control_reg <= irq_control_next;
    end
  end

  assign rdata = rdata_reg;
  assign irq_request = irq_reg;
  assign wdt_ps_tick = wdt_tick_reg;
endmodule

// *** bench/tou_timer_chk.sv ***
// concurrent checks on the register port and interrupt line of the timer unit
`timescale 1ns/100ps
`include "tou_params.svh"
module tou_timer_chk (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // register port
  input wire logic [`TOU_ADDR_W-1:0] addr,
  input wire tou_pkg::tou_byte_t wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire tou_pkg::tou_byte_t rdata,
  // status
  input wire logic sleep_mode,
  input wire logic irq_request
);
  import tou_pkg::*;
  logic ctl_wr, cnt_rd, gie_reg, gie_next;
  assign ctl_wr = wr_en && (addr == 8'h0B || addr == 8'h8B);
  assign cnt_rd = rd_en && addr == 8'h01;
  // shadow of the global enable as software last wrote it
  always_comb gie_next = ctl_wr ? wdata[7] : gie_reg;
  always_ff @(posedge clock) gie_reg <= srst ? 1'b0 : gie_next;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  sequence ctl_on_s;
    ctl_wr && wdata[7] && wdata[5] && wdata[2];
  endsequence
  sequence slp_rd_s;
    cnt_rd && sleep_mode;
  endsequence
  irq_raise_a: assert property (ctl_on_s ##1 !wr_en |=> irq_request)
    else $error("request missing");
  gie_off_a: assert property (ctl_wr && !wdata[7] ##1 !ctl_wr |=> !irq_request)
    else $error("request without global enable");
  gie_need_a: assert property (irq_request |-> $past(gie_reg))
    else $error("request while global enable clear");
  ovf_mask_a: assert property (ctl_wr && wdata[5:3] == 3'b000 ##1 !ctl_wr |=> !irq_request)
    else $error("request while enables clear");
  ctl_read_a: assert property (ctl_wr ##1 !wr_en ##1 (rd_en && addr == 8'h8B)
    |=> (rdata & 8'hF8) == ($past(wdata, 3) & 8'hF8))
    else $error("control readback differs");
  wr_hold_a: assert property (wr_en && addr == 8'h01 ##1 (!wr_en) [*4] ##1 cnt_rd |=> rdata == $past(wdata, 6))
    else $error("count moved during write hold");
  sleep_hold_a: assert property (slp_rd_s ##1 (sleep_mode && !wr_en) [*8] ##1 slp_rd_s |=> rdata == $past(rdata, 9))
    else $error("count moved in sleep");
  rd_zero_a: assert property (rd_en && addr == 8'h02 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind tou_timer_unit tou_timer_chk chk (.clock(clock), .srst(srst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
  .rd_en(rd_en), .rdata(rdata), .sleep_mode(sleep_mode), .irq_request(irq_request));

// *** bench/tou_pin_src.sv ***
// external count source toggling the count pin a set number of times
`timescale 1ns/100ps
module tou_pin_src (
  // control
  input wire logic clock,
  input wire logic start,
  input wire logic [7:0] toggles,
  input wire logic [7:0] spacing,
  // pin side
  output logic pin,
  output logic busy
);
  logic [7:0] left = 8'h00;
  logic [7:0] cnt = 8'h00;
  initial pin = 1'b0;
  assign busy = left != 8'h00;
  always @(posedge clock) begin
    if (start) begin
      left <= toggles;
      cnt <= 8'h00;
    end else if (busy && cnt >= spacing) begin
      pin <= ~pin;
      left <= left - 8'h01;
      cnt <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule

// *** bench/tou_timer_unit_tb_top.sv ***
// self-checking bench of the timer overflow unit
`timescale 1ns/100ps
module tou_timer_unit_tb_top;
  import tou_pkg::*;
  logic clock = 1'b0, srst = 1'b1, power_on_rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0, pin_go = 1'b0;
  logic sleep_mode = 1'b0, ext_pin_event = 1'b0, port_change_event = 1'b0, wdt_tick = 1'b0;
  logic ext_count_pin, irq_request, wdt_ps_tick, busy;
  logic [7:0] addr = 8'h00, toggles = 8'h00, spacing = 8'h02;
  tou_byte_t wdata = 8'h00, rdata, v, w;
  int n_fail = 0, cmp_count = 0;
  always #50 clock = ~clock;
  tou_timer_unit dut (.clock(clock), .srst(srst), .power_on_rst(power_on_rst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .ext_count_pin(ext_count_pin), .ext_pin_event(ext_pin_event),
    .port_change_event(port_change_event), .sleep_mode(sleep_mode), .wdt_tick(wdt_tick),
    .wdt_ps_tick(wdt_ps_tick), .irq_request(irq_request));
  tou_pin_src src (.clock(clock), .start(pin_go), .toggles(toggles), .spacing(spacing),
    .pin(ext_count_pin), .busy(busy));
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask
  // two count reads exactly cyc cycles apart
  task delta(input int cyc, input logic [7:0] e);
    rd(8'h01, v);
    repeat (cyc - 2) @(posedge clock);
    rd(8'h01, w);
    chk("count step", w - v, e);
  endtask
  function automatic logic exp_irq(input logic [7:0] c);
    return c[7] & |(c[5:3] & c[2:0]);
  endfunction
  function automatic logic [7:0] exp_edges(input logic s, input logic f, input logic [7:0] n);
    return (s == f) ? (n + 8'h01) >> 1 : n >> 1;
  endfunction
  task end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #3000000;
    n_fail++;
    end_sim();
  end
  initial begin
    int m, p;
    logic s;
    tou_byte_t corner [5];
    corner = '{8'hA4, 8'hA0, 8'h24, 8'h92, 8'h89};
    void'($urandom(26));
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    rd(8'h81, v);
    chk("option", v, 8'hFF);
    rd(8'h02, v);
    chk("unmapped", v, 8'h00);
    wr(8'h81, 8'h08);
    delta(40, 8'd10);
    for (int k = 0; k < 8; k++) begin
      wr(8'h81, 8'(k));
      p = 8 << k;
      m = 1 + $urandom % 3;
      repeat (p + 16) @(posedge clock);
      delta(p * m, 8'(m));
    end
    wdt_tick <= 1'b1;
    @(posedge clock);
    wdt_tick <= 1'b0;
    #1 chk("wdt pass", wdt_ps_tick, 8'h01);
    for (int f = 0; f < 2; f++) begin
      wr(8'h81, 8'h28 | 8'(f << 4));
      toggles <= 8'(1 + $urandom % 20);
      spacing <= 8'(2 + $urandom % 4);
      rd(8'h01, v);
      s = ext_count_pin;
      pin_go <= 1'b1;
      @(posedge clock);
      pin_go <= 1'b0;
      @(posedge clock);
      for (int i = 0; i < 300 && busy; i++) @(posedge clock);
      repeat (4) @(posedge clock);
      rd(8'h01, w);
      chk("pin edges", w - v, exp_edges(s, f[0], toggles));
    end
    wr(8'h81, 8'h08);
    wr(8'h0B, 8'h00);
    wr(8'h01, 8'hFE);
    repeat (3) @(posedge clock);
    rd(8'h01, v);
    chk("write hold", v, 8'hFE);
    ext_pin_event <= 1'b1;
    port_change_event <= 1'b1;
    @(posedge clock);
    ext_pin_event <= 1'b0;
    port_change_event <= 1'b0;
    repeat (40) @(posedge clock);
    rd(8'h0B, v);
    chk("flags", v, 8'h07);
    chk("masked", irq_request, 8'h00);
    sleep_mode <= 1'b1;
    delta(9, 8'h00);
    for (int i = 0; i < 16; i++) begin
      w = (i < 5) ? corner[i] : 8'($urandom);
      wr(8'h0B, w);
      rd(8'h8B, v);
      chk("control", v, w);
      chk("request", irq_request, exp_irq(w));
    end
    sleep_mode <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      wr(8'h0B, 8'hFF);
      power_on_rst <= i[0];
      srst <= 1'b1;
      repeat (2) @(posedge clock);
      srst <= 1'b0;
      rd(8'h0B, v);
      chk("control reset", v, i ? 8'h00 : 8'h01);
    end
    end_sim();
  end
endmodule
